// ### mrs_regs.svh
// Constants for the serial register-slave message handler
`ifndef MRS_REGS_SVH
`define MRS_REGS_SVH
`define MRS_FN_READ    8'h03
`define MRS_FN_WRMULT  8'h10
`define MRS_FN_LOG     8'h46
`define MRS_EXC_BIT    8'h80
`define MRS_EXC_FN     8'h01
`define MRS_EXC_ADDR   8'h02
`define MRS_EXC_VAL    8'h03
`define MRS_BCAST      8'h00
`define MRS_MAX_QTY    16'h007d
`define MRS_MAP_SIZE   17'h00400
`define MRS_CRC_INIT   16'hffff
`define MRS_CRC_POLY   16'ha001
`define MRS_RD_LEN     9'h008
`define MRS_WR_HDR     9'h009
`define MRS_MIN_LEN    9'h004
`define MRS_RX_LAST    9'h1ff
`define MRS_WR_DATA    9'h007
`define MRS_RD_DATA    8'h03
`define MRS_LEN_EXC    9'h003
`define MRS_LEN_WR     9'h006
`define MRS_LEN_LOG    9'h004
`define MRS_CLK_NS     25
`define MRS_GAP_NS     2005209
`define MRS_GAP_CYC    ((`MRS_GAP_NS + `MRS_CLK_NS - 1) / `MRS_CLK_NS)
`endif

// ### mrs_pkg.sv
// Types and CRC helper for the serial register-slave message handler
`include "mrs_regs.svh"
package mrs_pkg;
  typedef enum logic [1:0] {
    MRS_S_RX  = 2'h0,
    MRS_S_CHK = 2'h1,
    MRS_S_RUN = 2'h3,
    MRS_S_TX  = 2'h2
  } mrs_state_t;
  typedef struct packed {logic valid; logic err; logic [7:0] data;} mrs_rx_t;
  typedef struct packed {logic valid; logic [7:0] data;} mrs_tx_t;
  typedef struct packed {logic en; logic [15:0] addr; logic [15:0] data;} mrs_reg_t;
  function automatic logic [15:0] mrs_crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MRS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ### mrs_slave.sv
// Query parser, executor and response builder for the serial register slave
`timescale 1ns/100ps
`default_nettype none
`include "mrs_regs.svh"
module mrs_slave
  import mrs_pkg::*;
#(
  parameter int unsigned GAP_CYC = `MRS_GAP_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_station,
  input  wire mrs_rx_t     i_rx,
  input  wire logic        i_tx_ready,
  input  wire logic [15:0] i_reg_rd_data,
  output var  mrs_tx_t     o_tx,
  output var  mrs_reg_t    o_reg_rd,
  output var  mrs_reg_t    o_reg_wr,
  output var  logic        o_frame_err
);
  localparam logic [16:0] GAP_W = 17'(GAP_CYC);

  mrs_state_t  st_r, st_nxt;
  logic [8:0]  rx_len_r, rx_len_nxt;
  logic        rx_err_r, rx_err_nxt;
  logic [15:0] rx_crc_r, rx_crc_nxt;
  logic [16:0] gap_r, gap_nxt;
  logic [7:0]  fn_r, fn_nxt;
  logic [15:0] start_r, start_nxt;
  logic [15:0] qty_r, qty_nxt;
  logic        bc_r, bc_nxt;
  logic        exc_r, exc_nxt;
  logic [7:0]  idx_r, idx_nxt;
  logic        ph_r, ph_nxt;
  logic [8:0]  tx_len_r, tx_len_nxt;
  logic [8:0]  tx_idx_r, tx_idx_nxt;
  logic [15:0] tx_crc_r, tx_crc_nxt;
  logic [15:0] log_r, log_nxt;
  mrs_tx_t     tx_nxt;
  mrs_reg_t    rd_nxt, wr_nxt;
  logic        ferr_nxt;

  logic [7:0]  rxbuf [0:511];
  logic [7:0]  txbuf [0:255];
  logic [7:0]  hdr [0:5];
  logic        hdr_we;
  logic        rx_we;
  logic        rd_we;
  logic [7:0]  rd_pos;

  logic        chk_bad;
  logic [15:0] q_start;
  logic [15:0] q_qty;
  logic [16:0] q_end;
  logic [8:0]  wr_pos;
  logic [7:0]  tx_byte;

  assign q_start = {rxbuf[2], rxbuf[3]};
  assign q_qty   = {rxbuf[4], rxbuf[5]};
  assign q_end   = {1'b0, q_start} + {1'b0, q_qty};
  assign wr_pos  = `MRS_WR_DATA + {idx_r, 1'b0};
  assign rd_pos  = `MRS_RD_DATA + {idx_r[6:0], 1'b0};
  assign tx_byte = txbuf[tx_idx_r[7:0]];
  // The CRC over the whole frame, its own CRC field included, leaves zero when intact
  assign chk_bad = rx_err_r || (rx_len_r < `MRS_MIN_LEN) || (rx_crc_r != 16'h0000);

  always_comb begin
    st_nxt     = st_r;
    rx_len_nxt = rx_len_r;
    rx_err_nxt = rx_err_r;
    rx_crc_nxt = rx_crc_r;
    gap_nxt    = (gap_r >= GAP_W) ? gap_r : gap_r + 17'h00001;
    fn_nxt     = fn_r;
    start_nxt  = start_r;
    qty_nxt    = qty_r;
    bc_nxt     = bc_r;
    exc_nxt    = exc_r;
    idx_nxt    = idx_r;
    ph_nxt     = ph_r;
    tx_len_nxt = tx_len_r;
    tx_idx_nxt = tx_idx_r;
    tx_crc_nxt = tx_crc_r;
    log_nxt    = log_r;
    tx_nxt     = o_tx;
    rd_nxt     = o_reg_rd;
    rd_nxt.en  = 1'b0;
    wr_nxt     = o_reg_wr;
    wr_nxt.en  = 1'b0;
    ferr_nxt   = 1'b0;
    hdr_we     = 1'b0;
    rx_we      = 1'b0;
    rd_we      = 1'b0;
    for (int k = 0; k < 6; k++) begin
      hdr[k] = 8'h00;
    end
    if (i_rx.valid) begin
      gap_nxt = 17'h00000;
    end
    case (st_r)
      MRS_S_RX: begin
        if (i_rx.valid) begin
          // A byte that opens a frame without the full silence before it spoils it
          if (rx_len_r == 9'h000 && gap_r < GAP_W) begin
            rx_err_nxt = 1'b1;
          end
          if (i_rx.err || rx_len_r == `MRS_RX_LAST) begin
            rx_err_nxt = 1'b1;
          end else begin
            rx_we      = 1'b1;
            rx_len_nxt = rx_len_r + 9'h001;
          end
          rx_crc_nxt = mrs_crc_upd(rx_crc_r, i_rx.data);
        end else if (rx_len_r != 9'h000 && gap_r >= GAP_W) begin
          st_nxt = MRS_S_CHK;
        end
      end
      MRS_S_CHK: begin
        rx_len_nxt = 9'h000;
        rx_err_nxt = 1'b0;
        rx_crc_nxt = `MRS_CRC_INIT;
        fn_nxt     = rxbuf[1];
        start_nxt  = q_start;
        qty_nxt    = q_qty;
        bc_nxt     = (rxbuf[0] == `MRS_BCAST);
        exc_nxt    = 1'b0;
        idx_nxt    = 8'h00;
        ph_nxt     = 1'b0;
        tx_idx_nxt = 9'h000;
        tx_crc_nxt = `MRS_CRC_INIT;
        hdr[0]     = rxbuf[0];
        hdr[1]     = rxbuf[1];
        st_nxt     = MRS_S_RX;
        if (chk_bad) begin
          ferr_nxt = 1'b1;
        end else if (rxbuf[0] == i_station || rxbuf[0] == `MRS_BCAST) begin
          hdr_we = 1'b1;
          case (rxbuf[1])
            `MRS_FN_READ: begin
              if (rxbuf[0] == `MRS_BCAST) begin
                st_nxt = MRS_S_RX;
              end else if (rx_len_r != `MRS_RD_LEN || q_qty == 16'h0000
                           || q_qty > `MRS_MAX_QTY) begin
                exc_nxt = 1'b1;
                hdr[2]  = `MRS_EXC_VAL;
              end else if (q_end > `MRS_MAP_SIZE) begin
                exc_nxt = 1'b1;
                hdr[2]  = `MRS_EXC_ADDR;
              end else begin
                hdr[2]     = {q_qty[6:0], 1'b0};
                tx_len_nxt = `MRS_LEN_EXC + {q_qty[7:0], 1'b0};
                st_nxt     = MRS_S_RUN;
              end
            end
            `MRS_FN_WRMULT: begin
              if (q_qty == 16'h0000 || q_qty > `MRS_MAX_QTY || rxbuf[6] != {q_qty[6:0], 1'b0}
                  || rx_len_r != `MRS_WR_HDR + {q_qty[7:0], 1'b0}) begin
                exc_nxt = 1'b1;
                hdr[2]  = `MRS_EXC_VAL;
              end else if (q_end > `MRS_MAP_SIZE) begin
                exc_nxt = 1'b1;
                hdr[2]  = `MRS_EXC_ADDR;
              end else begin
                for (int k = 2; k < 6; k++) begin
                  hdr[k] = rxbuf[k];
                end
                tx_len_nxt = `MRS_LEN_WR;
                st_nxt     = MRS_S_RUN;
              end
            end
            `MRS_FN_LOG: begin
              if (rxbuf[0] != `MRS_BCAST) begin
                hdr[2]     = log_r[15:8];
                hdr[3]     = log_r[7:0];
                tx_len_nxt = `MRS_LEN_LOG;
                st_nxt     = MRS_S_TX;
              end
            end
            default: begin
              exc_nxt = 1'b1;
              hdr[2]  = `MRS_EXC_FN;
            end
          endcase
          if (exc_nxt) begin
            hdr[1]     = rxbuf[1] | `MRS_EXC_BIT;
            tx_len_nxt = `MRS_LEN_EXC;
            log_nxt    = 16'h0000;
            st_nxt     = (rxbuf[0] == `MRS_BCAST) ? MRS_S_RX : MRS_S_TX;
          end
        end
      end
      MRS_S_RUN: begin
        if (fn_r == `MRS_FN_READ) begin
          if (!ph_r) begin
            rd_nxt.en   = 1'b1;
            rd_nxt.addr = start_r + {8'h00, idx_r};
            rd_nxt.data = 16'h0000;
            ph_nxt      = 1'b1;
          end else begin
            rd_we   = 1'b1;
            ph_nxt  = 1'b0;
            idx_nxt = idx_r + 8'h01;
            if ({8'h00, idx_nxt} == qty_r) begin
              log_nxt = qty_r;
              st_nxt  = MRS_S_TX;
            end
          end
        end else begin
          wr_nxt.en   = 1'b1;
          wr_nxt.addr = start_r + {8'h00, idx_r};
          wr_nxt.data = {rxbuf[wr_pos], rxbuf[wr_pos + 9'h001]};
          idx_nxt     = idx_r + 8'h01;
          if ({8'h00, idx_nxt} == qty_r) begin
            log_nxt = qty_r;
            st_nxt  = bc_r ? MRS_S_RX : MRS_S_TX;
          end
        end
      end
      MRS_S_TX: begin
        if (!o_tx.valid || i_tx_ready) begin
          tx_nxt.valid = 1'b1;
          tx_idx_nxt   = tx_idx_r + 9'h001;
          if (tx_idx_r < tx_len_r) begin
            tx_nxt.data = tx_byte;
            tx_crc_nxt  = mrs_crc_upd(tx_crc_r, tx_byte);
          end else if (tx_idx_r == tx_len_r) begin
            tx_nxt.data = tx_crc_r[7:0];
          end else if (tx_idx_r == tx_len_r + 9'h001) begin
            tx_nxt.data = tx_crc_r[15:8];
          end else begin
            tx_nxt.valid = 1'b0;
            tx_idx_nxt   = tx_idx_r;
            st_nxt       = MRS_S_RX;
          end
        end
      end
      default: begin
        st_nxt = MRS_S_RX;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_r        <= MRS_S_RX;
      rx_len_r    <= 9'h000;
      rx_err_r    <= 1'b0;
      rx_crc_r    <= `MRS_CRC_INIT;
      gap_r       <= 17'h00000;
      fn_r        <= 8'h00;
      start_r     <= 16'h0000;
      qty_r       <= 16'h0000;
      bc_r        <= 1'b0;
      exc_r       <= 1'b0;
      idx_r       <= 8'h00;
      ph_r        <= 1'b0;
      tx_len_r    <= 9'h000;
      tx_idx_r    <= 9'h000;
      tx_crc_r    <= `MRS_CRC_INIT;
      log_r       <= 16'h0000;
      o_tx        <= '0;
      o_reg_rd    <= '0;
      o_reg_wr    <= '0;
      o_frame_err <= 1'b0;
    end else if (i_ce) begin
      st_r        <= st_nxt;
      rx_len_r    <= rx_len_nxt;
      rx_err_r    <= rx_err_nxt;
      rx_crc_r    <= rx_crc_nxt;
      gap_r       <= gap_nxt;
      fn_r        <= fn_nxt;
      start_r     <= start_nxt;
      qty_r       <= qty_nxt;
      bc_r        <= bc_nxt;
      exc_r       <= exc_nxt;
      idx_r       <= idx_nxt;
      ph_r        <= ph_nxt;
      tx_len_r    <= tx_len_nxt;
      tx_idx_r    <= tx_idx_nxt;
      tx_crc_r    <= tx_crc_nxt;
      log_r       <= log_nxt;
      o_tx        <= tx_nxt;
      o_reg_rd    <= rd_nxt;
      o_reg_wr    <= wr_nxt;
      o_frame_err <= ferr_nxt;
    end
  end

  // Buffers hold no control state, so they need no reset
  always_ff @(posedge i_ref_clk) begin
    if (i_ce) begin
      if (rx_we) begin
        rxbuf[rx_len_r] <= i_rx.data;
      end
      if (hdr_we) begin
        for (int k = 0; k < 6; k++) begin
          txbuf[k] <= hdr[k];
        end
      end
      if (rd_we) begin
        txbuf[rd_pos]        <= i_reg_rd_data[15:8];
        txbuf[rd_pos + 8'h01] <= i_reg_rd_data[7:0];
      end
    end
  end

  property p_crc_low_first;
    @(posedge i_ref_clk) disable iff (i_srst)
    (o_tx.valid && tx_idx_r == tx_len_r + 9'h001) |-> o_tx.data == tx_crc_r[7:0];
  endproperty
  a_crc_low_first: assert property (p_crc_low_first) else $error("CRC low byte wrong");

  property p_bad_drop;
    @(posedge i_ref_clk) disable iff (i_srst)
    (st_r == MRS_S_CHK && chk_bad && i_ce) |=> (st_r == MRS_S_RX && o_frame_err);
  endproperty
  a_bad_drop: assert property (p_bad_drop) else $error("Bad frame not dropped");

  property p_no_bcast_tx;
    @(posedge i_ref_clk) disable iff (i_srst)
    o_tx.valid |-> !bc_r;
  endproperty
  a_no_bcast_tx: assert property (p_no_bcast_tx) else $error("Broadcast answered");

  property p_exc_bit;
    @(posedge i_ref_clk) disable iff (i_srst)
    (o_tx.valid && tx_idx_r == 9'h002) |-> o_tx.data[7] == exc_r;
  endproperty
  a_exc_bit: assert property (p_exc_bit) else $error("Function bit 7 wrong");

  property p_byte_count;
    @(posedge i_ref_clk) disable iff (i_srst)
    (o_tx.valid && tx_idx_r == 9'h003 && fn_r == `MRS_FN_READ && !exc_r)
      |-> o_tx.data == {qty_r[6:0], 1'b0};
  endproperty
  a_byte_count: assert property (p_byte_count) else $error("Byte count wrong");

  property p_gap_end;
    @(posedge i_ref_clk) disable iff (i_srst)
    (st_r == MRS_S_CHK && $past(st_r) == MRS_S_RX) |-> $past(gap_r) >= GAP_W;
  endproperty
  a_gap_end: assert property (p_gap_end) else $error("Frame closed early");

  property p_rd_legal;
    @(posedge i_ref_clk) disable iff (i_srst)
    o_reg_rd.en |-> (!bc_r && qty_r != 16'h0000 && qty_r <= `MRS_MAX_QTY);
  endproperty
  a_rd_legal: assert property (p_rd_legal) else $error("Illegal read run");

  property p_rd_order;
    @(posedge i_ref_clk) disable iff (i_srst)
    o_reg_rd.en |-> o_reg_rd.addr == start_r + {8'h00, idx_r};
  endproperty
  a_rd_order: assert property (p_rd_order) else $error("Read address out of order");

  property p_wr_fn;
    @(posedge i_ref_clk) disable iff (i_srst)
    o_reg_wr.en |-> (fn_r == `MRS_FN_WRMULT && !exc_r);
  endproperty
  a_wr_fn: assert property (p_wr_fn) else $error("Write outside write function");
endmodule
`default_nettype wire

// ### mrs_master_model.sv
// Bus master side model: register store and response byte sink
`timescale 1ns/100ps
`default_nettype none
module mrs_master_model
  import mrs_pkg::*;
(
  input  wire logic     i_ref_clk,
  input  wire logic     i_slow,
  input  wire mrs_tx_t  i_tx,
  input  wire mrs_reg_t i_reg_rd,
  input  wire mrs_reg_t i_reg_wr,
  output var  logic        o_tx_ready,
  output var  logic [15:0] o_rd_data
);
  logic [15:0] mem [1024];
  logic [7:0]  got [$];
  logic [1:0]  cnt = 2'h0;
  initial begin
    foreach (mem[i]) mem[i] = 16'(i) ^ 16'hc35a;
  end
  // Slow mode is ready one cycle in four, so a held byte must not move meanwhile
  assign o_tx_ready = !i_slow || (cnt == 2'h3);
  // Off the read strobe the bus shows garbage, never the last good word
  assign o_rd_data = i_reg_rd.en ? mem[i_reg_rd.addr[9:0]] : ~mem[i_reg_rd.addr[9:0]];
  always @(posedge i_ref_clk) begin
    cnt <= cnt + 2'h1;
    if (i_tx.valid && o_tx_ready) got.push_back(i_tx.data);
    if (i_reg_wr.en) mem[i_reg_wr.addr[9:0]] <= i_reg_wr.data;
  end
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the serial register-slave message handler
`timescale 1ns/100ps
`default_nettype none
`include "mrs_regs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin miscompares++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  import mrs_pkg::*;
  localparam int GAP = 20;
  typedef struct {logic [7:0] sa, fn; logic [15:0] start, qty; logic [7:0] res;} mrs_row_t;
  logic        i_ref_clk   = 1'b0;
  logic        srst        = 1'b1;
  logic        slow        = 1'b0;
  mrs_rx_t     rx          = '0;
  mrs_tx_t     tx;
  mrs_reg_t    rd;
  mrs_reg_t    wr;
  logic        ready;
  logic        ferr;
  logic [15:0] rdata;
  logic [15:0] mirror [1024];
  logic [7:0]  f [$];
  logic [7:0]  ex [$];
  int          miscompares = 0;
  int          tests_run   = 0;
  int          cycles      = 0;
  int          quiet       = 0;
  int          errs        = 0;
  int          last_cnt    = 0;
  // Result ff means no answer; 00 a normal answer; else the exception code
  mrs_row_t    rows [20]   = '{
    '{8'h11, 8'h03, 16'h03eb, 16'h0003, 8'h00},
    '{8'h11, 8'h46, 16'h0000, 16'h0000, 8'h00},
    '{8'h11, 8'h03, 16'h0000, 16'h007d, 8'h00},
    '{8'h11, 8'h03, 16'h0000, 16'h0000, 8'h03},
    '{8'h11, 8'h46, 16'h0000, 16'h0000, 8'h00},
    '{8'h11, 8'h03, 16'h0000, 16'h007e, 8'h03},
    '{8'h11, 8'h03, 16'h03ff, 16'h0002, 8'h02},
    '{8'h11, 8'h03, 16'h03ff, 16'h0001, 8'h00},
    '{8'h00, 8'h03, 16'h0000, 16'h0001, 8'hff},
    '{8'h12, 8'h03, 16'h0000, 16'h0001, 8'hff},
    '{8'h11, 8'h06, 16'h0000, 16'h0001, 8'h01},
    '{8'h11, 8'h10, 16'h0100, 16'h0002, 8'h00},
    '{8'h11, 8'h03, 16'h0100, 16'h0002, 8'h00},
    '{8'h00, 8'h10, 16'h0200, 16'h0001, 8'hff},
    '{8'h11, 8'h03, 16'h0200, 16'h0001, 8'h00},
    '{8'h00, 8'h46, 16'h0000, 16'h0000, 8'hff},
    '{8'h00, 8'h10, 16'h0300, 16'h0002, 8'hff},
    '{8'h11, 8'h46, 16'h0000, 16'h0000, 8'h00},
    '{8'h11, 8'h10, 16'h03ff, 16'h0002, 8'h02},
    '{8'h11, 8'h10, 16'h0000, 16'h0000, 8'h03}
  };
  always #12.5 i_ref_clk = ~i_ref_clk;
  mrs_slave #(.GAP_CYC(GAP)) dut (
    .i_ref_clk(i_ref_clk), .i_srst(srst), .i_ce(1'b1), .i_station(8'h11), .i_rx(rx),
    .i_tx_ready(ready), .i_reg_rd_data(rdata), .o_tx(tx), .o_reg_rd(rd), .o_reg_wr(wr),
    .o_frame_err(ferr));
  mrs_master_model pm (.i_ref_clk(i_ref_clk), .i_slow(slow), .i_tx(tx), .i_reg_rd(rd),
    .i_reg_wr(wr), .o_tx_ready(ready), .o_rd_data(rdata));
  function automatic logic [15:0] crc16(input logic [7:0] b [$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction
  task automatic end_sim();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic send(input logic [15:0] crcx, input int bad);
    logic [15:0] c;
    c = crc16(f) ^ crcx;
    f = {f, c[7:0], c[15:8]};
    pm.got.delete();
    foreach (f[i]) begin
      @(posedge i_ref_clk);
      rx <= {1'b1, i == bad, f[i]};
      @(posedge i_ref_clk);
      rx <= '0;
    end
    tick(GAP + 4);
  endtask
  task automatic check_resp();
    logic [15:0] c;
    int          n;
    if (ex.size() > 0) begin
      c = crc16(ex);
      ex = {ex, c[7:0], c[15:8]};
    end
    for (n = 0; n < 4000 && !(pm.got.size() >= ex.size() && quiet > GAP + 8); n++) tick(1);
    // A response that never settles is a mismatch, not a silent pass
    `CHK("resp_settled", 1'b1, n < 4000)
    `CHK("length", ex.size(), pm.got.size())
    foreach (ex[i]) if (i < pm.got.size()) `CHK("byte", ex[i], pm.got[i])
  endtask
  task automatic run_row(input mrs_row_t r);
    logic [15:0] w;
    f = {r.sa, r.fn};
    if (r.fn != `MRS_FN_LOG) f = {f, r.start[15:8], r.start[7:0], r.qty[15:8], r.qty[7:0]};
    ex = {};
    if (r.fn == `MRS_FN_WRMULT) begin
      f.push_back(8'(2 * r.qty));
      for (int i = 0; i < r.qty; i++) begin
        w = (r.start + 16'(i)) ^ 16'h9e37;
        f = {f, w[15:8], w[7:0]};
        // Only a write that the slave carries out moves the reference copy
        if (r.res == 8'h00 || r.sa == `MRS_BCAST) mirror[r.start + 16'(i)] = w;
      end
      if (r.sa == `MRS_BCAST) last_cnt = r.qty;
    end
    if (r.res == 8'h00) begin
      ex = {r.sa, r.fn};
      if (r.fn == `MRS_FN_LOG) ex = {ex, 8'(last_cnt >> 8), 8'(last_cnt)};
      else last_cnt = r.qty;
      if (r.fn == `MRS_FN_WRMULT) ex = {ex, r.start[15:8], r.start[7:0], r.qty[15:8], r.qty[7:0]};
      if (r.fn == `MRS_FN_READ) begin
        ex.push_back(8'(2 * r.qty));
        for (int i = 0; i < r.qty; i++) begin
          w = mirror[r.start + 16'(i)];
          ex = {ex, w[15:8], w[7:0]};
        end
      end
    end else if (r.res != 8'hff) begin
      ex = {r.sa, r.fn | `MRS_EXC_BIT, r.res};
      last_cnt = 0;
    end
    send(16'h0000, -1);
    check_resp();
  endtask
  always @(posedge i_ref_clk) begin
    cycles++;
    quiet = (tx.valid === 1'b1) ? 0 : quiet + 1;
    if (ferr === 1'b1) errs++;
    if (cycles == 40000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    int c0;
    foreach (mirror[i]) mirror[i] = 16'(i) ^ 16'hc35a;
    tick(3);
    `CHK("tx_valid_in_reset", 1'b0, tx.valid)
    srst <= 1'b0;
    tick(GAP + 2);
    foreach (rows[k]) run_row(rows[k]);
    // Damaged CRC, then a character error: dropped silently but flagged
    for (int k = 0; k < 2; k++) begin
      f = {8'h11, `MRS_FN_READ, 8'h00, 8'h00, 8'h00, 8'h01};
      ex = {};
      c0 = errs;
      send(k == 0 ? 16'h0100 : 16'h0000, k == 0 ? -1 : 2);
      check_resp();
      `CHK("frame_err_count", c0 + 1, errs)
    end
    slow <= 1'b1;
    run_row(rows[0]);
    slow <= 1'b0;
    // Reset lands while a long read is walking the register file
    f = {8'h11, `MRS_FN_READ, 8'h00, 8'h00, 8'h00, 8'h7d};
    send(16'h0000, -1);
    srst <= 1'b1;
    tick(3);
    srst <= 1'b0;
    tick(1);
    `CHK("tx_after_reset", 1'b0, tx.valid)
    `CHK("rd_after_reset", 1'b0, rd.en)
    // A frame that starts before a full silence since reset is dropped and flagged
    f = {8'h11, `MRS_FN_READ, 8'h00, 8'h00, 8'h00, 8'h01};
    ex = {};
    c0 = errs;
    send(16'h0000, -1);
    check_resp();
    `CHK("early_frame_err", c0 + 1, errs)
    tick(GAP * 3);
    `CHK("late_bytes", 0, pm.got.size())
    run_row(rows[7]);
    end_sim();
  end
endmodule
`default_nettype wire
